/* File: common/fesc_pkg.sv */
// constants shared by the flash erase/suspend host controller
// assumes a 50 MHz pclk and a byte/word-selectable asynchronous parallel flash on the far side
package fesc_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_CFG = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_RDATA = 8'h14;
	// operation codes written to the control register
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_PROG = 4'h1;
	localparam logic [3:0] OP_SECT = 4'h2;
	localparam logic [3:0] OP_BLOCK = 4'h3;
	localparam logic [3:0] OP_CHIP = 4'h4;
	localparam logic [3:0] OP_SUSP = 4'h5;
	localparam logic [3:0] OP_RESUME = 4'h6;
	localparam logic [3:0] OP_RESET = 4'h7;
	// field positions
	localparam int CFG_WORD = 0;
	localparam int CFG_WP = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_SUSP = 3;
	localparam int ST_LOST = 4;
	localparam int ST_REFUSED = 5;
	localparam int ST_RDY_PIN = 6;
	// reset values
	localparam logic CFG_WORD_RST = 1'b1;
	localparam logic CFG_WP_RST = 1'b0;
	// flash command bytes and unlock cycles
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_SECTOR = 8'h50;
	localparam logic [7:0] CMD_BLOCK = 8'h30;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_PROG = 8'ha0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] UNLK_D1 = 8'haa;
	localparam logic [7:0] UNLK_D2 = 8'h55;
	localparam logic [10:0] UNLK_A1 = 11'h555;
	localparam logic [10:0] UNLK_A2 = 11'h2aa;
	// timing
	localparam int CLK_NS = 20;
	localparam int SUSPEND_LATENCY_NS = 10000;
	localparam int WE_LOW_NS = 40;
	localparam int RD_ACC_NS = 70;
	localparam int RESET_PULSE_MIN_NS = 500;
	localparam int RESET_RECOVERY_TIME_NS = 100;
	localparam logic [15:0] SUSPEND_CYC = 16'((SUSPEND_LATENCY_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] WE_CYC = 4'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RD_CYC = 4'((RD_ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] SYNC_CYC = 4'h2;
	localparam logic [15:0] RST_CYC = 16'((RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] REC_CYC = 16'((RESET_RECOVERY_TIME_NS + CLK_NS - 1) / CLK_NS);
endpackage

/* File: hdl/fesc_bus_cycle.sv */
// one asynchronous flash bus cycle, write or read, with registered pins
// assumes a single request at a time, start only while idle
module fesc_bus_cycle
	import fesc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request
	input wire logic start,
	input wire logic wr,
	input wire logic [21:0] addr,
	input wire logic [15:0] wdata,
	input wire logic word_mode,
	// answer
	output logic done,
	output logic [15:0] rdata,
	// flash pins
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [20:0] addr_pins,
	output logic [15:0] dq_out,
	output logic [15:0] dq_oe,
	input wire logic [15:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef enum logic [3:0] {
		B_IDLE = 4'b0001,
		B_SET = 4'b0010,
		B_ACT = 4'b0100,
		B_HOLD = 4'b1000
	} fesc_bstate_t;

	fesc_bstate_t st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic wr_reg, wr_next, done_reg, done_next;
	logic ce_n_reg, ce_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next;
	logic [20:0] a_reg, a_next;
	logic [15:0] dq_reg, dq_next, dqoe_reg, dqoe_next, rd_reg, rd_next;
	logic [15:0] s1_reg, s2_reg;

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		wr_next = wr_reg;
		a_next = a_reg;
		dq_next = dq_reg;
		dqoe_next = dqoe_reg;
		rd_next = rd_reg;
		done_next = 1'b0;
		unique case (st_reg)
			B_IDLE: if (start) begin
				wr_next = wr;
				a_next = word_mode ? addr[20:0] : addr[21:1];
				dq_next = word_mode ? wdata : {addr[0], 7'h00, wdata[7:0]};
				dqoe_next = word_mode ? {16{wr}} : {1'b1, 7'h00, {8{wr}}};
				st_next = B_SET;
			end
			B_SET: begin
				st_next = B_ACT;
				cnt_next = wr_reg ? WE_CYC : 4'(RD_CYC + SYNC_CYC);
			end
			B_ACT: if (cnt_reg == 4'h1) begin
				st_next = B_HOLD;
				if (!wr_reg)
					rd_next = s2_reg;
			end else begin
				cnt_next = cnt_reg - 4'h1;
			end
			B_HOLD: begin
				st_next = B_IDLE;
				dqoe_next = 16'h0000;
				done_next = 1'b1;
			end
		endcase
		ce_n_next = (st_next == B_IDLE);
		// output enable stays high for the whole write so the device never inhibits it
		we_n_next = !((st_next == B_ACT) && wr_next);
		oe_n_next = !((st_next == B_ACT) && !wr_next);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= B_IDLE;
			cnt_reg <= 4'h0;
			wr_reg <= 1'b0;
			a_reg <= 21'h000000;
			dq_reg <= 16'h0000;
			dqoe_reg <= 16'h0000;
			rd_reg <= 16'h0000;
			done_reg <= 1'b0;
			ce_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			s1_reg <= 16'h0000;
			s2_reg <= 16'h0000;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			wr_reg <= wr_next;
			a_reg <= a_next;
			dq_reg <= dq_next;
			dqoe_reg <= dqoe_next;
			rd_reg <= rd_next;
			done_reg <= done_next;
			ce_n_reg <= ce_n_next;
			we_n_reg <= we_n_next;
			oe_n_reg <= oe_n_next;
			s1_reg <= dq_in;
			s2_reg <= s1_reg;
		end
	end

	assign done = done_reg;
	assign rdata = rd_reg;
	assign ce_n = ce_n_reg;
	assign we_n = we_n_reg;
	assign oe_n = oe_n_reg;
	assign addr_pins = a_reg;
	assign dq_out = dq_reg;
	assign dq_oe = dqoe_reg;
endmodule

/* File: hdl/fesc_ctrl.sv */
// host controller for a dual-bank parallel flash: program, erase, suspend, resume, reset
// assumes an apb master on pclk and the flash pins resolved by the surroundings
module fesc_ctrl
	import fesc_pkg::*;
#(
	parameter logic [23:0] POLL_LIMIT = 24'hffffff
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flash pins
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n,
	output logic [20:0] fl_addr,
	output logic [15:0] fl_dq_out,
	output logic [15:0] fl_dq_oe,
	input wire logic [15:0] fl_dq_in,
	output logic fl_width_sel,
	output logic fl_wp_n,
	output logic fl_reset_n,
	input wire logic busy_ready_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef enum logic [7:0] {
		S_IDLE = 8'b00000001,
		S_WR = 8'b00000010,
		S_WRW = 8'b00000100,
		S_RD = 8'b00001000,
		S_RDW = 8'b00010000,
		S_SUSPW = 8'b00100000,
		S_RSTLO = 8'b01000000,
		S_RSTREC = 8'b10000000
	} fesc_state_t;

	function automatic logic fesc_is_erase(input logic [3:0] op);
		fesc_is_erase = (op == OP_SECT) || (op == OP_BLOCK) || (op == OP_CHIP);
	endfunction

	function automatic logic [2:0] fesc_last(input logic [3:0] op);
		if (op == OP_PROG)
			fesc_last = 3'h3;
		else if (fesc_is_erase(op))
			fesc_last = 3'h5;
		else
			fesc_last = 3'h0;
	endfunction

	function automatic logic [37:0] fesc_step(input logic [3:0] op, input logic [2:0] step,
		input logic [21:0] ua, input logic [15:0] ud, input logic wm);
		logic [21:0] a1;
		logic [21:0] a2;
		logic [7:0] code;
		a1 = wm ? {11'h000, UNLK_A1} : {10'h000, UNLK_A1, 1'b0};
		a2 = wm ? {11'h000, UNLK_A2} : {10'h000, UNLK_A2, 1'b0};
		code = (op == OP_SECT) ? CMD_SECTOR : (op == OP_BLOCK) ? CMD_BLOCK : CMD_CHIP;
		if (op == OP_SUSP)
			fesc_step = {ua, 8'h00, CMD_SUSPEND};
		else if (op == OP_RESUME)
			fesc_step = {ua, 8'h00, CMD_RESUME};
		else if (step == 3'h0 || step == 3'h3)
			fesc_step = (op == OP_PROG && step == 3'h3) ? {ua, ud} : {a1, 8'h00, UNLK_D1};
		else if (step == 3'h1 || step == 3'h4)
			fesc_step = {a2, 8'h00, UNLK_D2};
		else if (step == 3'h2)
			fesc_step = {a1, 8'h00, (op == OP_PROG) ? CMD_PROG : CMD_ERASE};
		else
			fesc_step = {(op == OP_CHIP) ? a1 : ua, 8'h00, code};
	endfunction

	fesc_state_t st_reg, st_next;
	logic [3:0] op_reg, op_next, eop_reg, eop_next;
	logic [2:0] step_reg, step_next;
	logic [1:0] rechk_reg, rechk_next;
	logic [23:0] poll_reg, poll_next;
	logic [15:0] tmr_reg, tmr_next, prev_reg, prev_next, rdata_reg, rdata_next;
	logic [21:0] addr_reg, addr_next;
	logic [15:0] wdata_reg, wdata_next;
	logic word_reg, word_next, wp_reg, wp_next, rstn_reg, rstn_next;
	logic havep_reg, havep_next, susp_reg, susp_next;
	logic spend_reg, spend_next, rpend_reg, rpend_next;
	logic done_reg, done_next, fail_reg, fail_next, lost_reg, lost_next, ref_reg, ref_next;
	logic rdy_s1_reg, rdy_s2_reg;
	logic [31:0] prdata_reg, prdata_next;
	logic wr_acc, rd_set, bus_start, bus_wr, bus_done, ev_done, ev_fail, ev_lost, ev_ref;
	logic valid, tog, polling;
	logic [3:0] op_w;
	logic [15:0] bus_rdata, vmask;
	logic [37:0] step_word;
	logic [31:0] stat_word;

	assign wr_acc = psel && penable && pwrite;
	assign rd_set = psel && !penable && !pwrite;
	assign op_w = pwdata[3:0];
	assign step_word = fesc_step(op_reg, step_reg, addr_reg, wdata_reg, word_reg);
	assign vmask = word_reg ? 16'hffff : 16'h00ff;
	assign valid = (op_reg == OP_PROG) ? ((bus_rdata & vmask) == (wdata_reg & vmask))
		: bus_rdata[7];
	assign tog = bus_rdata[6] != prev_reg[6];
	assign polling = (st_reg == S_RD) || (st_reg == S_RDW);
	assign stat_word = {25'h0, rdy_s2_reg, ref_reg, lost_reg, susp_reg, fail_reg, done_reg,
		st_reg != S_IDLE};

	always_comb begin
		st_next = st_reg;
		op_next = op_reg;
		eop_next = eop_reg;
		step_next = step_reg;
		rechk_next = rechk_reg;
		poll_next = poll_reg;
		tmr_next = tmr_reg;
		prev_next = prev_reg;
		rdata_next = rdata_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		word_next = word_reg;
		wp_next = wp_reg;
		havep_next = havep_reg;
		susp_next = susp_reg;
		spend_next = spend_reg;
		rpend_next = rpend_reg;
		bus_start = 1'b0;
		bus_wr = 1'b0;
		ev_done = 1'b0;
		ev_fail = 1'b0;
		ev_lost = 1'b0;
		ev_ref = 1'b0;
		if (wr_acc && st_reg == S_IDLE) begin
			if (paddr == REG_ADDR)
				addr_next = pwdata[21:0];
			if (paddr == REG_WDATA)
				wdata_next = pwdata[15:0];
		end
		if (wr_acc && paddr == REG_CFG) begin
			if (st_reg == S_IDLE && !susp_reg) begin
				word_next = pwdata[CFG_WORD];
				wp_next = pwdata[CFG_WP];
			end else begin
				ev_ref = 1'b1;
			end
		end
		if (wr_acc && paddr == REG_CTRL) begin
			if (st_reg == S_IDLE) begin
				if (op_w == OP_READ || op_w == OP_PROG) begin
					op_next = op_w;
					step_next = 3'h0;
					st_next = (op_w == OP_READ) ? S_RD : S_WR;
				end else if (op_w == OP_RESET) begin
					st_next = S_RSTLO;
					tmr_next = RST_CYC;
				end else if ((fesc_is_erase(op_w) && !susp_reg) || (op_w == OP_RESUME && susp_reg)) begin
					op_next = op_w;
					step_next = 3'h0;
					st_next = S_WR;
				end else begin
					ev_ref = 1'b1;
				end
			end else if (op_w == OP_SUSP && polling && fesc_is_erase(op_reg) && rechk_reg == 2'h0) begin
				spend_next = 1'b1;
			end else if (op_w == OP_RESET) begin
				rpend_next = 1'b1;
			end else begin
				ev_ref = 1'b1;
			end
		end
		unique case (st_reg)
			S_IDLE: begin
				// a suspend request left over from a finished erase must not hit the next one
				spend_next = 1'b0;
			end
			S_WR: begin
				bus_start = 1'b1;
				bus_wr = 1'b1;
				st_next = S_WRW;
			end
			S_WRW: if (bus_done) begin
				if (step_reg != fesc_last(op_reg)) begin
					step_next = step_reg + 3'h1;
					st_next = S_WR;
				end else if (op_reg == OP_SUSP) begin
					st_next = S_SUSPW;
					tmr_next = SUSPEND_CYC;
				end else begin
					// polling starts right after the last write edge
					if (op_reg == OP_RESUME) begin
						op_next = eop_reg;
						susp_next = 1'b0;
					end
					havep_next = 1'b0;
					poll_next = 24'h000000;
					rechk_next = 2'h0;
					st_next = S_RD;
				end
			end
			S_RD: if (rpend_reg) begin
				st_next = S_RSTLO;
				tmr_next = RST_CYC;
			end else if (spend_reg && fesc_is_erase(op_reg) && rechk_reg == 2'h0) begin
				spend_next = 1'b0;
				eop_next = op_reg;
				op_next = OP_SUSP;
				step_next = 3'h0;
				st_next = S_WR;
			end else begin
				bus_start = 1'b1;
				st_next = S_RDW;
			end
			S_RDW: if (bus_done) begin
				prev_next = bus_rdata;
				if (op_reg == OP_READ) begin
					rdata_next = bus_rdata;
					ev_done = 1'b1;
					st_next = S_IDLE;
				end else if (rechk_reg != 2'h0) begin
					rdata_next = bus_rdata;
					if (!valid) begin
						ev_fail = 1'b1;
						st_next = S_IDLE;
					end else if (rechk_reg == 2'h1) begin
						ev_done = 1'b1;
						st_next = S_IDLE;
					end else begin
						rechk_next = rechk_reg - 2'h1;
						st_next = S_RD;
					end
				end else if (!havep_reg) begin
					havep_next = 1'b1;
					st_next = S_RD;
				end else if (!tog && rdy_s2_reg) begin
					rdata_next = bus_rdata;
					if (valid) begin
						ev_done = 1'b1;
						st_next = S_IDLE;
					end else begin
						rechk_next = 2'h2;
						st_next = S_RD;
					end
				end else if (poll_reg == POLL_LIMIT) begin
					ev_fail = 1'b1;
					st_next = S_IDLE;
				end else begin
					poll_next = poll_reg + 24'h000001;
					st_next = S_RD;
				end
			end
			S_SUSPW: if (tmr_reg <= 16'h0001) begin
				susp_next = 1'b1;
				op_next = eop_reg;
				ev_done = 1'b1;
				st_next = S_IDLE;
			end else begin
				tmr_next = tmr_reg - 16'h0001;
			end
			S_RSTLO: if (tmr_reg <= 16'h0001) begin
				ev_lost = susp_reg || fesc_is_erase(op_reg) || fesc_is_erase(eop_reg);
				susp_next = 1'b0;
				rpend_next = 1'b0;
				spend_next = 1'b0;
				op_next = OP_READ;
				eop_next = OP_READ;
				tmr_next = REC_CYC;
				st_next = S_RSTREC;
			end else begin
				tmr_next = tmr_reg - 16'h0001;
			end
			S_RSTREC: if (tmr_reg <= 16'h0001) begin
				ev_done = 1'b1;
				st_next = S_IDLE;
			end else begin
				tmr_next = tmr_reg - 16'h0001;
			end
		endcase
		rstn_next = (st_next != S_RSTLO);
		// sticky flags: a new event wins over a clear in the same cycle
		done_next = ev_done || (done_reg && !(wr_acc && paddr == REG_STAT && pwdata[ST_DONE]));
		fail_next = ev_fail || (fail_reg && !(wr_acc && paddr == REG_STAT && pwdata[ST_FAIL]));
		lost_next = ev_lost || (lost_reg && !(wr_acc && paddr == REG_STAT && pwdata[ST_LOST]));
		ref_next = ev_ref || (ref_reg && !(wr_acc && paddr == REG_STAT && pwdata[ST_REFUSED]));
		prdata_next = prdata_reg;
		if (rd_set) begin
			unique case (paddr)
				REG_CTRL: prdata_next = {28'h0, op_reg};
				REG_ADDR: prdata_next = {10'h0, addr_reg};
				REG_WDATA: prdata_next = {16'h0, wdata_reg};
				REG_CFG: prdata_next = {30'h0, wp_reg, word_reg};
				REG_STAT: prdata_next = stat_word;
				REG_RDATA: prdata_next = {16'h0, rdata_reg};
				default: prdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= S_IDLE;
			op_reg <= OP_READ;
			eop_reg <= OP_READ;
			step_reg <= 3'h0;
			rechk_reg <= 2'h0;
			poll_reg <= 24'h000000;
			tmr_reg <= 16'h0000;
			prev_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
			addr_reg <= 22'h000000;
			wdata_reg <= 16'h0000;
			word_reg <= CFG_WORD_RST;
			wp_reg <= CFG_WP_RST;
			rstn_reg <= 1'b1;
			havep_reg <= 1'b0;
			susp_reg <= 1'b0;
			spend_reg <= 1'b0;
			rpend_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			lost_reg <= 1'b0;
			ref_reg <= 1'b0;
			rdy_s1_reg <= 1'b0;
			rdy_s2_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			st_reg <= st_next;
			op_reg <= op_next;
			eop_reg <= eop_next;
			step_reg <= step_next;
			rechk_reg <= rechk_next;
			poll_reg <= poll_next;
			tmr_reg <= tmr_next;
			prev_reg <= prev_next;
			rdata_reg <= rdata_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			word_reg <= word_next;
			wp_reg <= wp_next;
			rstn_reg <= rstn_next;
			havep_reg <= havep_next;
			susp_reg <= susp_next;
			spend_reg <= spend_next;
			rpend_reg <= rpend_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
			lost_reg <= lost_next;
			ref_reg <= ref_next;
			rdy_s1_reg <= busy_ready_out_n;
			rdy_s2_reg <= rdy_s1_reg;
			prdata_reg <= prdata_next;
		end
	end

	fesc_bus_cycle u_bus (
		.pclk(pclk),
		.presetn(presetn),
		.start(bus_start),
		.wr(bus_wr),
		.addr(bus_wr ? step_word[37:16] : addr_reg),
		.wdata(step_word[15:0]),
		.word_mode(word_reg),
		.done(bus_done),
		.rdata(bus_rdata),
		.ce_n(fl_ce_n),
		.we_n(fl_we_n),
		.oe_n(fl_oe_n),
		.addr_pins(fl_addr),
		.dq_out(fl_dq_out),
		.dq_oe(fl_dq_oe),
		.dq_in(fl_dq_in)
	);

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == REG_CTRL || paddr == REG_ADDR ||
		paddr == REG_WDATA || paddr == REG_CFG || paddr == REG_STAT || paddr == REG_RDATA);
	assign fl_width_sel = word_reg;
	assign fl_wp_n = wp_reg;
	assign fl_reset_n = rstn_reg;
endmodule

/* File: verif/fesc_checker.sv */
// assertions on the flash pins and apb answer of the host controller
// bound onto every fesc_ctrl instance; sees its ports only
module fesc_checker
	import fesc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	// flash pins
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic [15:0] fl_dq_oe,
	input wire logic fl_width_sel,
	input wire logic fl_wp_n,
	input wire logic fl_reset_n,
	input wire logic busy_ready_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rst_lo_reg;
	logic [15:0] rst_lo_next;
	// counts cycles the flash reset pin is held low
	always_comb begin
		rst_lo_next = fl_reset_n ? 16'h0000 : rst_lo_reg + 16'h0001;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_lo_reg <= 16'h0000;
		end else begin
			rst_lo_reg <= rst_lo_next;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	write_strobe_a: assert property (!fl_we_n |-> fl_oe_n && !fl_ce_n)
		else $error("write strobe with output enable or no select");
	we_width_a: assert property ($fell(fl_we_n) |-> ##1 !fl_we_n ##1 fl_we_n)
		else $error("write strobe width wrong");
	read_release_a: assert property (!fl_oe_n |-> fl_we_n && fl_dq_oe[7:0] == 8'h00)
		else $error("host drives data during read");
	byte_float_a: assert property (!fl_width_sel && !fl_ce_n |-> fl_dq_oe[14:8] == 7'h00)
		else $error("floating data pins driven in byte mode");
	slverr_phase_a: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access phase");
	reset_pulse_a: assert property ($rose(fl_reset_n) |-> rst_lo_reg >= RST_CYC)
		else $error("flash reset pulse too short");
	reset_recover_a: assert property ($rose(fl_reset_n) |-> fl_ce_n [*5])
		else $error("access before reset recovery");
	reset_quiet_a: assert property (!fl_reset_n |-> fl_ce_n && fl_dq_oe == 16'h0000)
		else $error("bus active during flash reset");
	wp_steady_a: assert property (!busy_ready_out_n && !$past(busy_ready_out_n) |-> $stable(fl_wp_n))
		else $error("write protect moved during operation");
	cover property ($rose(fl_reset_n));
	cover property (!fl_width_sel && !fl_oe_n);
	cover property ($fell(busy_ready_out_n));
endmodule

bind fesc_ctrl fesc_checker fesc_checker_i (.pclk, .presetn, .psel, .penable, .pslverr, .fl_ce_n,
	.fl_we_n, .fl_oe_n, .fl_dq_oe, .fl_width_sel, .fl_wp_n, .fl_reset_n, .busy_ready_out_n);

/* File: verif/fesc_flash_model.sv */
// behavioural dual-bank flash: command decode, status bits, busy pin, reset
// assumes registered host strobes; pclk samples the host strobes and also times the internal operations
module fesc_flash_model
	import fesc_pkg::*;
#(
	parameter int PROG_CYC = 30,
	parameter int ERASE_CYC = 400
)
(
	// clock
	input wire logic pclk,
	// flash pins
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic [20:0] fl_addr,
	input wire logic [15:0] fl_dq_out,
	output logic [15:0] fl_dq_in,
	input wire logic fl_wp_n,
	input wire logic fl_reset_n,
	output logic busy_ready_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [logic [20:0]];
	logic [2:0] step = 3'h0;
	logic busy = 1'b0, erase = 1'b0, susp = 1'b0, tog = 1'b0, we_q = 1'b1, oe_q = 1'b1, ok;
	logic [20:0] op_a = 21'h0, sus_a = 21'h0;
	logic [15:0] op_d = 16'h0, rd, last = 16'h0;
	int cnt = 0;
	assign busy_ready_out_n = !busy;
	// released data lines show the inverse of the last driven value
	assign fl_dq_in = (!fl_ce_n && !fl_oe_n && fl_reset_n) ? rd : ~last;
	always @* begin
		rd = mem.exists(fl_addr) ? mem[fl_addr] : 16'hffff;
		if (busy && fl_addr[20] == op_a[20]) begin
			rd = erase ? {8'h00, 1'b0, tog, 3'h0, tog, 2'h0}
				: {op_d[15:8], ~op_d[7], tog, op_d[5:0]};
		end else if (susp && fl_addr[20:11] == sus_a[20:11]) begin
			rd = {8'h00, 2'h3, 3'h0, tog, 2'h0};
		end
	end
	task automatic start(input logic e, input int n);
		busy <= 1'b1;
		erase <= e;
		cnt <= n;
		op_a <= fl_addr;
		op_d <= fl_dq_out;
	endtask
	task automatic cmd();
		logic [10:0] a;
		logic [7:0] d;
		a = fl_addr[10:0];
		d = fl_dq_out[7:0];
		ok = (fl_wp_n || fl_addr[20:13] != 8'h00) && !(susp && fl_addr[20:11] == sus_a[20:11]);
		if (busy) begin
			if (erase && d == CMD_SUSPEND) begin
				busy <= 1'b0;
				susp <= 1'b1;
				sus_a <= op_a;
			end
		end else if (susp && step == 3'h0 && d == CMD_RESUME) begin
			busy <= 1'b1;
			erase <= 1'b1;
			susp <= 1'b0;
			cnt <= 100;
		end else begin
			step <= 3'h0;
			case (step)
				3'h0, 3'h3: if (a == UNLK_A1 && d == UNLK_D1) step <= step + 3'h1;
				3'h1, 3'h4: if (a == UNLK_A2 && d == UNLK_D2) step <= step + 3'h1;
				3'h2: step <= (d == CMD_PROG) ? 3'h6 : (d == CMD_ERASE) ? 3'h3 : 3'h0;
				3'h5: if (!susp) start(1'b1, ERASE_CYC);
				3'h6: if (ok) begin
					mem[fl_addr] = fl_dq_out;
					start(1'b0, PROG_CYC);
				end
				default: step <= 3'h0;
			endcase
		end
	endtask
	always @(posedge pclk) begin
		we_q <= fl_we_n;
		oe_q <= fl_oe_n;
		if (!fl_ce_n && !fl_oe_n) begin
			last <= fl_dq_in;
		end
		if (oe_q && !fl_oe_n) begin
			tog <= !tog;
		end
		if (!fl_reset_n) begin
			{busy, erase, susp, step} <= '0;
		end else if (!we_q && fl_we_n && !fl_ce_n && fl_oe_n) begin
			cmd();
		end else if (busy && cnt > 0) begin
			cnt <= cnt - 1;
		end else if (busy) begin
			busy <= 1'b0;
			if (erase) begin
				mem.delete();
			end
		end
	end
endmodule

/* File: verif/tb.sv */
// self-checking bench: apb master driving the host controller against the flash model
// assumes the checker is attached by its bind statement
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fesc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, t2;
	logic fl_ce_n, fl_we_n, fl_oe_n, fl_width_sel, fl_wp_n, fl_reset_n, busy_ready_out_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [20:0] fl_addr, cap_a;
	logic [15:0] fl_dq_out, fl_dq_oe, fl_dq_in, cap_d;
	int n_mismatch, check_count, cycles;
	fesc_ctrl #(.POLL_LIMIT(24'h000100)) fesc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_addr,
		.fl_dq_out, .fl_dq_oe, .fl_dq_in, .fl_width_sel, .fl_wp_n, .fl_reset_n, .busy_ready_out_n);
	fesc_flash_model fesc_flash_model_i (.pclk, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_addr,
		.fl_dq_out, .fl_dq_in, .fl_wp_n, .fl_reset_n, .busy_ready_out_n);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(negedge fl_oe_n) begin
		cap_a = fl_addr;
		cap_d = {fl_dq_out[15], fl_dq_oe[15], 14'h0};
	end
	task automatic print_verdict();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic go(input logic [3:0] op);
		apb(1'b1, REG_STAT, 32'h36);
		apb(1'b1, REG_CTRL, {28'h0, op});
	endtask
	task automatic idle();
		do apb(1'b0, REG_STAT, 32'h0); while (r[ST_BUSY] !== 1'b0);
	endtask
	task automatic low();
		do apb(1'b0, REG_STAT, 32'h0); while (r[ST_RDY_PIN] !== 1'b0);
	endtask
	task automatic read_at(input logic [31:0] a);
		apb(1'b1, REG_ADDR, a);
		go(OP_READ);
		idle();
		apb(1'b0, REG_RDATA, 32'h0);
	endtask
	task automatic t_reset();
		chk("pins", 32'h5, {29'h0, fl_width_sel, fl_wp_n, fl_reset_n});
		apb(1'b0, REG_CFG, 32'h0);
		chk("cfg", {30'h0, CFG_WP_RST, CFG_WORD_RST}, r);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		go(OP_SUSP);
		apb(1'b0, REG_STAT, 32'h0);
		chk("idle suspend", 32'h60, r);
	endtask
	task automatic t_prog();
		apb(1'b1, REG_CFG, 32'h3);
		apb(1'b1, REG_ADDR, 32'h100020);
		apb(1'b1, REG_WDATA, 32'h1234);
		go(OP_PROG);
		low();
		idle();
		chk("prog status", 32'h42, r);
		read_at(32'h100020);
		chk("prog data", 32'h1234, r);
	endtask
	task automatic t_protect();
		apb(1'b1, REG_CFG, 32'h1);
		apb(1'b1, REG_ADDR, 32'h10);
		apb(1'b1, REG_WDATA, 32'h00a5);
		go(OP_PROG);
		idle();
		chk("protected fail", 32'h1, {31'h0, r[ST_FAIL]});
		chk("wp pin", 32'h0, {31'h0, fl_wp_n});
	endtask
	task automatic t_suspend();
		apb(1'b1, REG_CFG, 32'h3);
		apb(1'b1, REG_ADDR, 32'h100800);
		go(OP_SECT);
		low();
		go(OP_SUSP);
		idle();
		chk("suspended", 32'h4a, {25'h0, r[6:0]});
		read_at(32'h100810);
		t2 = r[2];
		chk("susp bits", 32'h3, {30'h0, r[7:6]});
		read_at(32'h100810);
		chk("erase toggle", 32'h1, {31'h0, t2 ^ r[2]});
		read_at(32'h000020);
		chk("other bank", 32'hffff, r);
		apb(1'b1, REG_ADDR, 32'h101000);
		apb(1'b1, REG_WDATA, 32'h0055);
		go(OP_PROG);
		idle();
		chk("susp prog", 32'h4a, {25'h0, r[6:0]});
		apb(1'b1, REG_ADDR, 32'h100820);
		go(OP_PROG);
		idle();
		chk("susp sector prog", 32'h1, {31'h0, r[ST_FAIL]});
		apb(1'b1, REG_ADDR, 32'h100800);
		go(OP_RESUME);
		idle();
		chk("resumed", 32'h42, {25'h0, r[6:0]});
		read_at(32'h100800);
		chk("erased", 32'hffff, r);
	endtask
	task automatic t_erase_reset();
		apb(1'b1, REG_ADDR, 32'h108000);
		go(OP_BLOCK);
		idle();
		chk("block", 32'h42, {25'h0, r[6:0]});
		go(OP_CHIP);
		low();
		go(OP_RESET);
		idle();
		chk("reset lost", 32'h52, {25'h0, r[6:0]});
	endtask
	task automatic t_byte();
		apb(1'b1, REG_CFG, 32'h2);
		read_at(32'h4021);
		chk("byte addr", 32'h2010, {11'h0, cap_a});
		chk("byte a-1", 32'hc000, {16'h0, cap_d});
		chk("width pin", 32'h0, {31'h0, fl_width_sel});
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		n_mismatch = 0;
		check_count = 0;
		cycles = 0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_prog();
		t_protect();
		t_suspend();
		t_erase_reset();
		t_byte();
		print_verdict();
	end
endmodule
